/* verilog/rxdc_pkg.sv */
// Package with register map, field layout and reset values of the block
package rxdc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_THRESHOLD = 8'h18;
	localparam logic [7:0] IDX_DEMOD = 8'h19;
	localparam logic [7:0] IDX_RX_CONTROL = 8'h20;
	localparam logic [7:0] IDX_PRESCALE = 8'h21;
	localparam logic [7:0] IDX_STATUS = 8'h22;
	// Reset values
	localparam logic [7:0] RST_THRESHOLD = 8'h84;
	localparam logic [7:0] RST_DEMOD = 8'h4d;
	localparam logic [7:0] RST_RX_CONTROL = 8'h00;
	// Writable bits; bit 3 of the threshold register is reserved
	localparam logic [7:0] MASK_THRESHOLD = 8'hf7;
	// Threshold fields
	localparam int MIN_LEVEL_LSB = 4;
	localparam int COLL_LEVEL_LSB = 0;
	// Demodulator fields
	localparam int COMBINE_LSB = 6;
	localparam int FIX_BIT = 5;
	localparam int EVEN_BIT = 4;
	localparam int TAU_RCV_LSB = 2;
	localparam int TAU_SYNC_LSB = 0;
	// Receive control fields
	localparam int INSEL_LSB = 6;
	localparam int GUARD_LSB = 0;
	// Input selection codes
	localparam logic [1:0] INSEL_LOW = 2'h0;
	localparam logic [1:0] INSEL_ENVELOPE = 2'h1;
	localparam logic [1:0] INSEL_ANALOG = 2'h2;
	localparam logic [1:0] INSEL_SENSE = 2'h3;
	// Channel combine codes
	localparam logic [1:0] COMB_STRONG = 2'h0;
	localparam logic [1:0] COMB_FREEZE = 2'h1;
	localparam logic [1:0] COMB_IQ = 2'h2;
	// Receiver commands
	localparam logic [3:0] CMD_RECEIVE = 4'h8;
	localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
	localparam logic [3:0] CMD_AUTOCOLL = 4'hd;
	localparam logic [3:0] CMD_AUTHENTICATE = 4'he;
	// Loop constant that freezes the PLL
	localparam logic [1:0] TAU_FROZEN = 2'h0;
	// Width of the prescale value
	localparam int PRESCALE_W = 12;
	// Receive channel in use
	typedef enum logic [1:0] {RXDC_CH_I, RXDC_CH_Q, RXDC_CH_IQ} rxdc_chan_t;
endpackage

/* verilog/rxdc_prescaler.sv */
// Timer tick generator with odd or even divide ratio
`timescale 1ns/1ps
module rxdc_prescaler #(
	parameter int W = rxdc_pkg::PRESCALE_W
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Settings
	input wire logic [W-1:0] prescale,
	input wire logic even_select,
	// Tick out
	output logic tick
);
	logic [W+1:0] count;
	logic [W+1:0] next_count;
	logic [W+1:0] last;
	logic next_tick;

	// Ratio 2P+1 or 2P+2; count runs from 0 to ratio-1
	always_comb begin
		last = {1'b0, prescale, 1'b0} + {{(W+1){1'b0}}, even_select};
		if (count >= last) begin
			next_count = '0;
			next_tick = 1'b1;
		end else begin
			next_count = count + 1'b1;
			next_tick = 1'b0;
		end
	end

	// Counter registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule

/* verilog/rxdc_top.sv */
// Receive decoder and demodulator configuration with APB register access
// Function
// - Select code 11 takes modulation from the sense input pin.
// - After transmit, receiver held off for guard delay bit-clocks.
// - Plain receive skips guard; transceive, autocoll, authenticate apply it.
// - Passive mode: guard count starts at last transmitted modulation pulse.
// - Active mode: guard count starts once external field is on.
// - Decoder evaluates input only at or above minimum signal level.
// - Collision only when weaker half-bit reaches collision level of stronger.
// - Threshold bit 3 reserved; unused, reads zero.
// - Combine code: 00 stronger, 01 stronger frozen, 10 I+Q, 11 reserved.
// - Combine codes act only while channel fix bit is zero.
// - Fix bit set and combine X1: receive on Q only.
// - Even select clear: timer tick divides by twice prescale plus one.
// - Even select set: timer tick divides by twice prescale plus two.
// - Reception loop constant sets PLL during data; 00 freezes PLL.
// - Burst loop constant sets PLL during the preceding burst.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module rxdc_top #(
	parameter int PW = rxdc_pkg::PRESCALE_W,
	parameter int AW = 8
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Command and link events
	input wire logic [3:0] command,
	input wire logic active_mode,
	input wire logic tx_last_pulse,
	input wire logic ext_field_on,
	input wire logic bit_clk_tick,
	// Receive signal sources
	input wire logic analog_mod,
	input wire logic sense_input_pin,
	input wire logic sense_envelope,
	output logic rx_signal,
	output logic guard_active,
	// Bit decoder
	input wire logic sample_valid,
	input wire logic [3:0] signal_strength,
	input wire logic [AW-1:0] strong_half,
	input wire logic [AW-1:0] weak_half,
	output logic decode_valid,
	output logic bit_collision,
	// Channel choice
	input wire logic comm_active,
	input wire logic [AW-1:0] i_strength,
	input wire logic [AW-1:0] q_strength,
	output rxdc_pkg::rxdc_chan_t channel,
	// Timer and PLL
	output logic timer_tick,
	input wire logic rx_burst,
	input wire logic rx_data,
	output logic [1:0] pll_tau,
	output logic pll_freeze
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] decoder_threshold;
	logic [7:0] demodulator_settings;
	logic [7:0] rx_control;
	logic [PW-1:0] timer_prescale_value;
	logic [7:0] next_decoder_threshold;
	logic [7:0] next_demodulator_settings;
	logic [7:0] next_rx_control;
	logic [PW-1:0] next_timer_prescale_value;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [7:0] index;
	logic access;
	logic wr_en;

	// Field views
	logic [3:0] min_signal_level;
	logic [2:0] collision_level;
	logic [1:0] channel_combine_select;
	logic channel_fix;
	logic prescaler_even_select;
	logic [1:0] reception_loop_constant;
	logic [1:0] burst_loop_constant;
	logic [1:0] input_select;
	logic [5:0] receive_guard_delay;

	assign min_signal_level = decoder_threshold[rxdc_pkg::MIN_LEVEL_LSB +: 4];
	assign collision_level = decoder_threshold[rxdc_pkg::COLL_LEVEL_LSB +: 3];
	assign channel_combine_select =
		demodulator_settings[rxdc_pkg::COMBINE_LSB +: 2];
	assign channel_fix = demodulator_settings[rxdc_pkg::FIX_BIT];
	assign prescaler_even_select = demodulator_settings[rxdc_pkg::EVEN_BIT];
	assign reception_loop_constant =
		demodulator_settings[rxdc_pkg::TAU_RCV_LSB +: 2];
	assign burst_loop_constant =
		demodulator_settings[rxdc_pkg::TAU_SYNC_LSB +: 2];
	assign input_select = rx_control[rxdc_pkg::INSEL_LSB +: 2];
	assign receive_guard_delay = rx_control[rxdc_pkg::GUARD_LSB +: 6];

	// Word index from byte address
	function automatic logic [7:0] word_index(input logic [11:0] a);
		word_index = a[9:2];
	endfunction

	// Read mux; unmapped addresses answer an error
	function automatic logic [32:0] read_word(input logic [7:0] idx,
		input logic [31:0] status);
		case (idx)
			rxdc_pkg::IDX_THRESHOLD: read_word = {1'b0, 24'h0,
				decoder_threshold & rxdc_pkg::MASK_THRESHOLD};
			rxdc_pkg::IDX_DEMOD: read_word = {1'b0, 24'h0, demodulator_settings};
			rxdc_pkg::IDX_RX_CONTROL: read_word = {1'b0, 24'h0, rx_control};
			rxdc_pkg::IDX_PRESCALE: read_word = {1'b0,
				{(32-PW){1'b0}}, timer_prescale_value};
			rxdc_pkg::IDX_STATUS: read_word = {1'b0, status};
			default: read_word = {1'b1, 32'h0};
		endcase
	endfunction

	logic [31:0] status_word;
	logic [32:0] rd;
	assign status_word = {24'h0, 1'b0, channel, guard_active, rx_signal,
		pll_freeze, bit_collision, decode_valid};
	assign index = word_index(paddr);
	assign access = psel && penable;
	assign wr_en = access && pready && pwrite && !pslverr;
	// Read mux in a process: the function reads the registers directly,
	// so a plain assign would not wake up when only a register changes
	always_comb begin
		rd = read_word(index, status_word);
	end

	// Bus next state: one wait cycle, write lands when pready is high
	always_comb begin
		next_decoder_threshold = decoder_threshold;
		next_demodulator_settings = demodulator_settings;
		next_rx_control = rx_control;
		next_timer_prescale_value = timer_prescale_value;
		next_pready = access && !pready;
		next_pslverr = access && !pready && rd[32];
		next_prdata = prdata;
		if (access && !pready && !pwrite) begin
			next_prdata = rd[31:0];
		end
		if (wr_en) begin
			case (index)
				rxdc_pkg::IDX_THRESHOLD: next_decoder_threshold =
					pwdata[7:0] & rxdc_pkg::MASK_THRESHOLD;
				rxdc_pkg::IDX_DEMOD: next_demodulator_settings =
					pwdata[7:0];
				rxdc_pkg::IDX_RX_CONTROL: next_rx_control = pwdata[7:0];
				rxdc_pkg::IDX_PRESCALE: next_timer_prescale_value =
					pwdata[PW-1:0];
				default: next_rx_control = rx_control;
			endcase
		end
	end

	// Bus and register flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decoder_threshold <= rxdc_pkg::RST_THRESHOLD;
			demodulator_settings <= rxdc_pkg::RST_DEMOD;
			rx_control <= rxdc_pkg::RST_RX_CONTROL;
			timer_prescale_value <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			decoder_threshold <= next_decoder_threshold;
			demodulator_settings <= next_demodulator_settings;
			rx_control <= next_rx_control;
			timer_prescale_value <= next_timer_prescale_value;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Guard delay after transmission
	logic [5:0] guard_count;
	logic [5:0] next_guard_count;
	logic guard_cmd;
	logic guard_start;
	logic next_guard_active;
	logic next_rx_signal;
	logic raw_rx;

	// Plain receive has no guard; other receive commands do
	assign guard_cmd = (command == rxdc_pkg::CMD_TRANSCEIVE) ||
		(command == rxdc_pkg::CMD_AUTOCOLL) ||
		(command == rxdc_pkg::CMD_AUTHENTICATE);
	assign guard_start = guard_cmd &&
		(active_mode ? ext_field_on : tx_last_pulse);

	// Guard counter and gated receive signal
	always_comb begin
		next_guard_count = guard_count;
		if (guard_start) begin
			next_guard_count = receive_guard_delay;
		end else if (bit_clk_tick && guard_count != 6'h0) begin
			next_guard_count = guard_count - 6'h1;
		end
		next_guard_active = next_guard_count != 6'h0;
		case (input_select)
			rxdc_pkg::INSEL_LOW: raw_rx = 1'b0;
			rxdc_pkg::INSEL_ENVELOPE: raw_rx = sense_envelope;
			rxdc_pkg::INSEL_ANALOG: raw_rx = analog_mod;
			rxdc_pkg::INSEL_SENSE: raw_rx = sense_input_pin;
			default: raw_rx = 1'b0;
		endcase
		next_rx_signal = next_guard_active ? 1'b0 : raw_rx;
	end

	// Guard flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_count <= 6'h0;
			guard_active <= 1'b0;
			rx_signal <= 1'b0;
		end else begin
			guard_count <= next_guard_count;
			guard_active <= next_guard_active;
			rx_signal <= next_rx_signal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit decoder thresholds
	logic next_decode_valid;
	logic next_bit_collision;
	logic [AW+2:0] weak_scaled;
	logic [AW+2:0] strong_scaled;

	// Weak half scaled by 8 against strong half times the collision level
	always_comb begin
		weak_scaled = {weak_half, 3'h0};
		strong_scaled = {3'h0, strong_half} * {{AW{1'b0}}, collision_level};
		next_decode_valid = sample_valid &&
			(signal_strength >= min_signal_level);
		next_bit_collision = next_decode_valid &&
			(weak_scaled >= strong_scaled);
	end

	// Decoder flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decode_valid <= 1'b0;
			bit_collision <= 1'b0;
		end else begin
			decode_valid <= next_decode_valid;
			bit_collision <= next_bit_collision;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel selection
	rxdc_pkg::rxdc_chan_t next_channel;
	rxdc_pkg::rxdc_chan_t stronger;
	logic frozen;
	logic next_frozen;

	always_comb begin
		stronger = (q_strength > i_strength) ? rxdc_pkg::RXDC_CH_Q :
			rxdc_pkg::RXDC_CH_I;
		next_frozen = 1'b0;
		next_channel = channel;
		if (channel_fix) begin
			next_channel = channel_combine_select[0] ?
				rxdc_pkg::RXDC_CH_Q :
				rxdc_pkg::RXDC_CH_I;
		end else begin
			case (channel_combine_select)
				rxdc_pkg::COMB_STRONG: next_channel = stronger;
				rxdc_pkg::COMB_FREEZE: begin
					next_frozen = comm_active;
					if (!frozen) begin
						next_channel = stronger;
					end
				end
				rxdc_pkg::COMB_IQ: next_channel = rxdc_pkg::RXDC_CH_IQ;
				default: next_channel = channel;
			endcase
		end
	end

	// Channel flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel <= rxdc_pkg::RXDC_CH_I;
			frozen <= 1'b0;
		end else begin
			channel <= next_channel;
			frozen <= next_frozen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer prescaler
	rxdc_prescaler #(
		.W(PW)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.prescale(timer_prescale_value),
		.even_select(prescaler_even_select),
		.tick(timer_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// PLL time constant
	logic [1:0] next_pll_tau;
	logic next_pll_freeze;

	always_comb begin
		next_pll_tau = pll_tau;
		next_pll_freeze = 1'b0;
		if (rx_data) begin
			next_pll_tau = reception_loop_constant;
			next_pll_freeze =
				reception_loop_constant == rxdc_pkg::TAU_FROZEN;
		end else if (rx_burst) begin
			next_pll_tau = burst_loop_constant;
		end
	end

	// PLL flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_tau <= 2'h0;
			pll_freeze <= 1'b0;
		end else begin
			pll_tau <= next_pll_tau;
			pll_freeze <= next_pll_freeze;
		end
	end
endmodule

/* testbench/rxdc_top_assertions.sv */
// Port checker for the receive decoder and demodulator configuration
`timescale 1ns/1ps
module rxdc_top_assertions #(
	parameter int AW = 8
) (
	// APB
	input wire logic pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Guard and PLL
	input wire logic [3:0] command,
	input wire logic active_mode, tx_last_pulse, ext_field_on,
	input wire logic rx_signal, guard_active, rx_data, pll_freeze,
	// Decoder and channel
	input wire logic sample_valid, decode_valid, bit_collision,
	input wire logic [3:0] signal_strength,
	input wire logic [AW-1:0] strong_half, weak_half,
	input rxdc_pkg::rxdc_chan_t channel
);
	logic [7:0] thr, dem, rxc;
	logic wr_done, guard_cmd, dec_ok, coll_ok;
	////////////////////////////////////////////////////////////////////////
	// Shadow of the registers, taken when a write completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr <= rxdc_pkg::RST_THRESHOLD;
			dem <= rxdc_pkg::RST_DEMOD;
			rxc <= rxdc_pkg::RST_RX_CONTROL;
		end else if (wr_done) begin
			if (paddr == 12'h060) thr <= pwdata[7:0] & rxdc_pkg::MASK_THRESHOLD;
			if (paddr == 12'h064) dem <= pwdata[7:0];
			if (paddr == 12'h080) rxc <= pwdata[7:0];
		end
	end
	// Decoded conditions
	assign wr_done = psel && penable && pready && pwrite;
	assign guard_cmd = command inside {rxdc_pkg::CMD_TRANSCEIVE,
		rxdc_pkg::CMD_AUTOCOLL, rxdc_pkg::CMD_AUTHENTICATE};
	assign dec_ok = sample_valid && signal_strength >= thr[7:4];
	assign coll_ok = (weak_half * 11'h8) >= (strong_half * {8'h0, thr[2:0]});
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_guard_mute: assert property (guard_active |-> !rx_signal)
		else $error("receive signal passed during guard");
	chk_receive_noguard: assert property (
		command == rxdc_pkg::CMD_RECEIVE && !guard_active |=> !guard_active)
		else $error("plain receive started the guard");
	chk_passive_start: assert property (
		!active_mode && tx_last_pulse && guard_cmd && rxc[5:0] != 6'h0
		|-> ##[1:2] guard_active) else $error("passive guard did not start");
	chk_active_start: assert property (
		active_mode && ext_field_on && guard_cmd && rxc[5:0] != 6'h0
		|-> ##[1:2] guard_active) else $error("active guard did not start");
	chk_level_accept: assert property (dec_ok |=> decode_valid)
		else $error("strong sample not evaluated");
	chk_level_drop: assert property (
		sample_valid && !dec_ok |=> !decode_valid)
		else $error("weak sample evaluated");
	chk_coll_report: assert property (dec_ok && coll_ok |=> bit_collision)
		else $error("collision not reported");
	chk_fix_q: assert property (
		(dem[5] && dem[6]) [*2] |-> channel == rxdc_pkg::RXDC_CH_Q)
		else $error("fixed Q channel not used");
	chk_fix_i: assert property (
		(dem[5] && !dem[6]) [*2] |-> channel == rxdc_pkg::RXDC_CH_I)
		else $error("fixed I channel not used");
	chk_pll_frozen: assert property (
		rx_data && dem[3:2] == rxdc_pkg::TAU_FROZEN |=> pll_freeze)
		else $error("PLL not frozen during reception");
	// Main scenarios reached
	cov_guard: cover property ($rose(guard_active));
	cov_coll: cover property (bit_collision);
	cov_freeze: cover property (pll_freeze);
endmodule

bind rxdc_top rxdc_top_assertions #(.AW(AW)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
	.command, .active_mode, .tx_last_pulse, .ext_field_on, .rx_signal,
	.guard_active, .rx_data, .pll_freeze, .sample_valid, .decode_valid,
	.bit_collision, .signal_strength, .strong_half, .weak_half, .channel
);

/* testbench/rxdc_apb_host.sv */
// APB master standing in for host software
`timescale 1ns/1ps
module rxdc_apb_host (
	// Clock
	input wire logic pclk,
	// APB master side
	output logic psel, penable, pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready, pslverr
);
	// Idle bus from time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	// One transfer: setup, then access held until pready is sampled high
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench of the receive decoder and demodulator configuration
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'h0, presetn = 1'h0, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] command = 4'h0, signal_strength = 4'h0;
	logic active_mode = 0, tx_last_pulse = 0, ext_field_on = 0, bit_clk_tick = 0;
	logic analog_mod = 0, sense_input_pin = 0, sense_envelope = 0;
	logic sample_valid = 0, comm_active = 0, rx_burst = 0, rx_data = 0;
	logic [7:0] strong_half = 8'h0, weak_half = 8'h0;
	logic [7:0] i_strength = 8'h10, q_strength = 8'h20;
	logic rx_signal, guard_active, decode_valid, bit_collision;
	logic timer_tick, pll_freeze;
	logic [1:0] pll_tau;
	rxdc_pkg::rxdc_chan_t channel;
	int mismatches = 0, comparisons = 0, n;
	logic [29:0] rows [6];
	logic [9:0] chans [7];
	////////////////////////////////////////////////////////////////////////
	rxdc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .command, .active_mode,
		.tx_last_pulse, .ext_field_on, .bit_clk_tick, .analog_mod,
		.sense_input_pin, .sense_envelope, .rx_signal, .guard_active,
		.sample_valid, .signal_strength, .strong_half, .weak_half,
		.decode_valid, .bit_collision, .comm_active, .i_strength,
		.q_strength, .channel, .timer_tick, .rx_burst, .rx_data, .pll_tau,
		.pll_freeze);
	rxdc_apb_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	always #2 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t saw %h wanted %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		u_host.xfer(1'h1, a, {24'h0, d}, rd, er);
	endtask
	task automatic r(input logic [11:0] a, input logic [31:0] exp);
		u_host.xfer(1'h0, a, 32'h0, rd, er);
		chk(rd, exp);
	endtask
	// One-cycle pulses of {bit-clock, field on, last pulse}, k times
	task automatic evt(input logic [2:0] m, input int k);
		repeat (k) begin
			@(posedge pclk) {bit_clk_tick, ext_field_on, tx_last_pulse} <= m;
			@(posedge pclk) {bit_clk_tick, ext_field_on, tx_last_pulse} <= 3'h0;
		end
	endtask
	// Cycles between two timer ticks
	task automatic period(output int p);
		p = 0;
		do @(posedge pclk); while (timer_tick !== 1'h1);
		do begin @(posedge pclk); p++; end while (timer_tick !== 1'h1);
	endtask
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		// Threshold, strength, strong, weak, expected valid and collision
		rows = '{{8'h84, 4'h8, 8'h40, 8'h20, 2'h3}, {8'h84, 4'h7, 8'h40, 8'h20, 2'h0},
			{8'h84, 4'h8, 8'h40, 8'h1f, 2'h2}, {8'h0c, 4'h0, 8'h10, 8'h07, 2'h2},
			{8'hf7, 4'hf, 8'h08, 8'h07, 2'h3}, {8'hf7, 4'he, 8'h08, 8'h07, 2'h0}};
		// Demodulator byte and channel expected while Q is stronger
		chans = '{{8'h60, 2'h1}, {8'h20, 2'h0}, {8'ha0, 2'h0}, {8'he0, 2'h1},
			{8'h80, 2'h2}, {8'h00, 2'h1}, {8'hc0, 2'h1}};
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		r(12'h060, 32'h84);
		r(12'h064, 32'h4d);
		foreach (rows[i]) begin
			w(12'h060, rows[i][29:22]);
			@(posedge pclk)
				{sample_valid, signal_strength, strong_half, weak_half} <= {1'h1, rows[i][21:2]};
			@(posedge pclk) sample_valid <= 1'h0;
			#1;
			chk(decode_valid, rows[i][1]);
			chk(bit_collision, rows[i][0]);
		end
		// Reserved bit, full demodulator byte, unmapped place
		w(12'h060, 8'hff);
		r(12'h060, 32'hf7);
		w(12'h064, 8'hb2);
		r(12'h064, 32'hb2);
		r(12'h0fc, 32'h0);
		chk(er, 1'h1);
		w(12'h0fc, 8'h55);
		chk(er, 1'h1);
		// Other sources in turn with no guard: low, envelope, analog
		for (int s = 0; s < 3; s++) begin
			{analog_mod, sense_envelope, sense_input_pin} <=
				(s == 0) ? 3'h7 : {s[1], s[0], 1'h0};
			w(12'h080, {s[1:0], 6'h0});
			step(3);
			chk(rx_signal, s != 0);
		end
		// Sense input with a guard of three bit-clocks for each guarded command, then plain receive with none
		w(12'h080, 8'hc3);
		{analog_mod, sense_input_pin} <= 2'h1;
		step(3);
		chk(rx_signal, 1'h1);
		for (int c = 0; c < 3; c++) begin
			@(posedge pclk) command <= rxdc_pkg::CMD_TRANSCEIVE + c[3:0];
			evt(3'h1, 1);
			step(1);
			chk(guard_active, 1'h1);
			chk(rx_signal, 1'h0);
			evt(3'h4, 2);
			step(1);
			chk(guard_active, 1'h1);
			evt(3'h4, 1);
			step(2);
			chk(guard_active, 1'h0);
		end
		@(posedge pclk) command <= rxdc_pkg::CMD_RECEIVE;
		evt(3'h1, 1);
		step(2);
		chk(guard_active, 1'h0);
		// Active mode waits for the field, not the last pulse
		@(posedge pclk) active_mode <= 1'h1;
		command <= rxdc_pkg::CMD_TRANSCEIVE;
		evt(3'h1, 1);
		step(2);
		chk(guard_active, 1'h0);
		evt(3'h2, 1);
		step(1);
		chk(guard_active, 1'h1);
		// Channel choice, fixed and combined
		foreach (chans[i]) begin
			w(12'h064, chans[i][9:2]);
			step(3);
			chk(channel, chans[i][1:0]);
		end
		// Frozen choice survives a swap of strengths in communication
		w(12'h064, 8'h40);
		comm_active <= 1'h1;
		step(2);
		@(posedge pclk) i_strength <= 8'h30;
		step(3);
		chk(channel, 2'h1);
		@(posedge pclk) comm_active <= 1'h0;
		step(3);
		chk(channel, 2'h0);
		// Timer ratio with prescale 3, odd then even
		w(12'h084, 8'h03);
		r(12'h084, 32'h3);
		for (int e = 0; e < 2; e++) begin
			w(12'h064, {3'h0, e[0], 4'h0});
			period(n);
			period(n);
			chk(n, 7 + e);
		end
		// PLL constants for burst and reception, then frozen
		w(12'h064, 8'h09);
		rx_burst <= 1'h1;
		step(2);
		chk(pll_tau, 2'h1);
		@(posedge pclk) rx_data <= 1'h1;
		step(2);
		chk(pll_tau, 2'h2);
		chk(pll_freeze, 1'h0);
		w(12'h064, 8'h01);
		step(2);
		chk(pll_freeze, 1'h1);
		// Status: PLL frozen, guard still running, I channel stronger
		r(12'h088, 32'h14);
		// A second reset restores the defaults
		@(posedge pclk) presetn <= 1'h0;
		@(posedge pclk) presetn <= 1'h1;
		r(12'h064, 32'h4d);
		r(12'h060, 32'h84);
		chk(guard_active, 1'h0);
		summarize();
	end
endmodule
